// file: hw/dccu_top.sv
// dual capture/compare unit: two units of sixteen channels, four timers, AXI4-Lite registers
// Summary of operation
// RULE_01: two units of sixteen channels each, thirty-two channels total.
// RULE_02: smallest prescaler gives the finest timer step, eight clocks.
// RULE_03: each unit has two 16-bit timers each with a reload register.
// RULE_04: timer counts on prescaled clock or second module output timer overflow.
// RULE_05: first timer of each unit may also count external pin edges.
// RULE_06: each channel selects either timer of its own unit.
// RULE_07: each channel independently set to capture or a compare mode.
// RULE_08: each channel owns one pin: capture input or compare output.
// RULE_09: channels 24 to 27 are input only, no compare output.
// RULE_10: shared external count input makes both first timers count together; here each first timer has its own ext_count_in line.
// RULE_11: capture copies assigned timer into channel register on pin event.
// RULE_12: every capture raises that channel's own interrupt request.
// RULE_13: capture edge is rising, falling or both, per channel.
// RULE_14: compare channels check against their timer on each timer update.
// RULE_15: on equality the configured compare mode action is carried out.
// RULE_16: period depends on reload; zero reload runs the full 16-bit range.
// RULE_17: prescaler choice in each timer's input select sets its rate.
// RULE_18: input select codes 0 to 7 divide clock by 8 up to 1024.
// RULE_19: mode 0 interrupts every match; mode 1 toggles pin every match.
// RULE_20: mode 3 sets pin on match, clears on overflow; mode 2 one irq a period.
// RULE_21: double mode: two registers toggle one pin on every match.
// RULE_22: timer reloads on overflow in the same clock and raises its request.
//
// Chosen here: the address map and register access over AXI4-Lite.
`default_nettype none
module dccu_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dccu_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dccu_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic gpt_ovf_pulse,
  input wire logic [1:0] ext_count_in,
  input wire logic [dccu_pkg::NUM_CH-1:0] cc_pin_in,
  output logic [dccu_pkg::NUM_CH-1:0] cc_pin_out,
  output logic [dccu_pkg::NUM_CH-1:0] cc_pin_oe,
  output logic [dccu_pkg::NUM_CH-1:0] cc_irq,
  output logic [dccu_pkg::NUM_TMR-1:0] timer_irq
);
  function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    wmerge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // register state
  logic [15:0] cc_val_reg [dccu_pkg::NUM_CH];
  dccu_pkg::dccu_ch_cfg_type cc_cfg_reg [dccu_pkg::NUM_CH];
  logic [15:0] tmr_reg [dccu_pkg::NUM_TMR];
  logic [15:0] rld_reg [dccu_pkg::NUM_TMR];
  dccu_pkg::dccu_tmr_ctl_type tctl_reg [dccu_pkg::NUM_TMR];
  logic [dccu_pkg::PRESC_W-1:0] presc_reg;
  logic [1:0] ext_prev_reg;
  logic [dccu_pkg::NUM_CH-1:0] pin_prev_reg;
  logic [dccu_pkg::NUM_CH-1:0] fired_reg;

  // timer events shared with channels
  logic [dccu_pkg::NUM_TMR-1:0] tmr_tick;
  logic [dccu_pkg::NUM_TMR-1:0] tmr_ovf;
  logic [15:0] tmr_next [dccu_pkg::NUM_TMR];
  logic [dccu_pkg::NUM_CH-1:0] ch_match;
  logic [dccu_pkg::NUM_CH-1:0] ch_dbl;

  // ---------------- AXI4-Lite write path ----------------
  logic aw_held_reg;
  logic w_held_reg;
  logic [dccu_pkg::AXI_AW-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  wire logic wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  wire logic [6:0] wr_idx = awaddr_reg[8:2];
  wire logic wr_hit = wr_idx < dccu_pkg::IDX_END;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  // the register write lands at the edge that raises bvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      bvalid_reg <= 1'b0;
      bresp_reg <= dccu_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? dccu_pkg::RESP_OKAY : dccu_pkg::RESP_SLVERR;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  wire logic [6:0] rd_idx = s_axi_araddr[8:2];
  wire logic rd_hit_val = rd_idx < dccu_pkg::IDX_CFG;
  wire logic rd_hit_cfg = !rd_hit_val && rd_idx < dccu_pkg::IDX_TMR;
  wire logic rd_hit_tmr = rd_idx >= dccu_pkg::IDX_TMR && rd_idx < dccu_pkg::IDX_RLD;
  wire logic rd_hit_rld = rd_idx >= dccu_pkg::IDX_RLD && rd_idx < dccu_pkg::IDX_TCTL;
  wire logic rd_hit_tctl = rd_idx >= dccu_pkg::IDX_TCTL && rd_idx < dccu_pkg::IDX_END;
  wire logic rd_hit = rd_idx < dccu_pkg::IDX_END;
  wire logic [31:0] rd_word =
    rd_hit_val ? 32'(cc_val_reg[rd_idx[4:0]]) :
    rd_hit_cfg ? 32'(cc_cfg_reg[rd_idx[4:0]]) :
    rd_hit_tmr ? 32'(tmr_reg[rd_idx[1:0]]) :
    rd_hit_rld ? 32'(rld_reg[rd_idx[1:0]]) :
    rd_hit_tctl ? 32'(tctl_reg[rd_idx[1:0]]) : 32'h0000_0000;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // read data is taken from the registers at the edge that accepts the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= dccu_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= rd_hit ? dccu_pkg::RESP_OKAY : dccu_pkg::RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ---------------- prescaler and external count edges ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_reg <= '0;
      ext_prev_reg <= '0;
    end else begin
      presc_reg <= presc_reg + 1'b1;
      ext_prev_reg <= ext_count_in;
    end
  end

  // ---------------- timers ----------------
  for (genvar t = 0; t < dccu_pkg::NUM_TMR; t++) begin : g_tmr
    dccu_pkg::dccu_tmr_ctl_type ctl;
    logic [dccu_pkg::PRESC_W-1:0] mask;
    logic presc_tick;
    logic ext_ev;
    logic src_tick;
    assign ctl = tctl_reg[t];
    // divide by 8 << select: 8, 16 ... 1024
    assign mask = dccu_pkg::PRESC_W'((dccu_pkg::PRESC_BASE << ctl.timer_input_select)
                  - dccu_pkg::PRESC_ONE); // RULE_18 RULE_17 RULE_02
    assign presc_tick = (presc_reg & mask) == mask;
    if (t % 2 == 0) begin : g_ext
      // each first timer counts edges of its own unit's ext_count_in line, per its own ext_edge
      wire logic rise = ext_count_in[t/2] && !ext_prev_reg[t/2];
      wire logic fall = !ext_count_in[t/2] && ext_prev_reg[t/2];
      assign ext_ev = (ctl.ext_edge[0] && rise) || (ctl.ext_edge[1] && fall); // RULE_05 RULE_10
    end else begin : g_noext
      assign ext_ev = 1'b0;
    end
    assign src_tick = (ctl.src == dccu_pkg::DCCU_SRC_PRESC) ? presc_tick :
                      (ctl.src == dccu_pkg::DCCU_SRC_GPT) ? gpt_ovf_pulse :
                      (ctl.src == dccu_pkg::DCCU_SRC_EXT) ? ext_ev : 1'b0; // RULE_04
    assign tmr_tick[t] = ctl.run && src_tick;
    assign tmr_ovf[t] = tmr_tick[t] && tmr_reg[t] == dccu_pkg::TMR_MAX;
    // reload of zero runs the full range
    assign tmr_next[t] = tmr_ovf[t] ? rld_reg[t] : tmr_reg[t] + dccu_pkg::TMR_ONE; // RULE_16

    wire logic wr_t = wr_fire && wr_idx == dccu_pkg::IDX_TMR + 7'(t);
    wire logic wr_r = wr_fire && wr_idx == dccu_pkg::IDX_RLD + 7'(t);
    wire logic wr_c = wr_fire && wr_idx == dccu_pkg::IDX_TCTL + 7'(t) && wstrb_reg[0];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        tmr_reg[t] <= dccu_pkg::TMR_RST;
        rld_reg[t] <= dccu_pkg::TMR_RST;
        tctl_reg[t] <= '0;
        timer_irq[t] <= 1'b0;
      end else begin
        if (wr_t) begin
          tmr_reg[t] <= wmerge(tmr_reg[t], wdata_reg, wstrb_reg);
        end else if (tmr_tick[t]) begin
          tmr_reg[t] <= tmr_next[t]; // RULE_03 RULE_22
        end
        if (wr_r) begin
          rld_reg[t] <= wmerge(rld_reg[t], wdata_reg, wstrb_reg); // RULE_03
        end
        if (wr_c) begin
          tctl_reg[t] <= dccu_pkg::dccu_tmr_ctl_type'(wdata_reg[dccu_pkg::TCTL_W-1:0]);
        end
        timer_irq[t] <= tmr_ovf[t]; // RULE_22
      end
    end
  end

  // ---------------- channels ----------------
  for (genvar i = 0; i < dccu_pkg::NUM_CH; i++) begin : g_ch // RULE_01
    localparam bit OUT_OK = !(i >= dccu_pkg::IN_ONLY_LO && i <= dccu_pkg::IN_ONLY_HI);
    dccu_pkg::dccu_ch_cfg_type cfg;
    logic [1:0] ti;
    logic rise;
    logic fall;
    logic cap_ev;
    logic is_cmp;
    logic once_ok;
    logic pair_match;
    logic low_half;
    assign cfg = cc_cfg_reg[i];
    // timer index: unit number and per-channel timer choice
    assign ti = {1'(i / dccu_pkg::CH_PER_UNIT), cfg.tmr_sel}; // RULE_06
    assign rise = cc_pin_in[i] && !pin_prev_reg[i];
    assign fall = !cc_pin_in[i] && pin_prev_reg[i];
    assign cap_ev = cfg.mode == dccu_pkg::DCCU_CAPTURE &&
                    ((cfg.edge_sel[0] && rise) || (cfg.edge_sel[1] && fall)); // RULE_13 RULE_08
    assign is_cmp = cfg.mode inside {dccu_pkg::DCCU_CMP0, dccu_pkg::DCCU_CMP1,
                    dccu_pkg::DCCU_CMP2, dccu_pkg::DCCU_CMP3, dccu_pkg::DCCU_DOUBLE}; // RULE_07
    // compare against the value the timer takes on this update
    assign ch_match[i] = is_cmp && tmr_tick[ti] && cc_val_reg[i] == tmr_next[ti]; // RULE_14
    assign ch_dbl[i] = cfg.mode == dccu_pkg::DCCU_DOUBLE;
    assign once_ok = ch_match[i] && (!fired_reg[i] || tmr_ovf[ti]);
    assign low_half = (i % dccu_pkg::CH_PER_UNIT) < dccu_pkg::PAIR_OFS;
    if ((i % dccu_pkg::CH_PER_UNIT) < dccu_pkg::PAIR_OFS) begin : g_pair
      assign pair_match = ch_dbl[i] && ch_dbl[i + dccu_pkg::PAIR_OFS] &&
                          ch_match[i + dccu_pkg::PAIR_OFS]; // RULE_21
    end else begin : g_nopair
      assign pair_match = 1'b0;
    end

    wire logic wr_v = wr_fire && wr_idx == dccu_pkg::IDX_VAL + 7'(i);
    wire logic wr_c = wr_fire && wr_idx == dccu_pkg::IDX_CFG + 7'(i) && wstrb_reg[0];

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cc_val_reg[i] <= '0;
        cc_cfg_reg[i] <= '0;
        pin_prev_reg[i] <= 1'b0;
        fired_reg[i] <= 1'b0;
        cc_irq[i] <= 1'b0;
      end else begin
        pin_prev_reg[i] <= cc_pin_in[i];
        // capture wins over a software write in the same cycle
        if (cap_ev) begin
          cc_val_reg[i] <= tmr_reg[ti]; // RULE_11
        end else if (wr_v) begin
          cc_val_reg[i] <= wmerge(cc_val_reg[i], wdata_reg, wstrb_reg);
        end
        if (wr_c) begin
          cc_cfg_reg[i] <= dccu_pkg::dccu_ch_cfg_type'(wdata_reg[dccu_pkg::CFG_W-1:0]);
        end
        // a match on the reload value belongs to the new period;
        // a new config starts the channel with no match counted, a match wins
        if (tmr_ovf[ti]) begin
          fired_reg[i] <= ch_match[i];
        end else if (ch_match[i]) begin
          fired_reg[i] <= 1'b1;
        end else if (wr_c) begin
          fired_reg[i] <= 1'b0;
        end
        // requests are one-cycle pulses for an outside interrupt controller
        unique case (cfg.mode)
          dccu_pkg::DCCU_CAPTURE: cc_irq[i] <= cap_ev; // RULE_12
          dccu_pkg::DCCU_CMP0, dccu_pkg::DCCU_CMP1, dccu_pkg::DCCU_DOUBLE:
            cc_irq[i] <= ch_match[i]; // RULE_19 RULE_15
          dccu_pkg::DCCU_CMP2, dccu_pkg::DCCU_CMP3: cc_irq[i] <= once_ok; // RULE_20
          default: cc_irq[i] <= 1'b0;
        endcase
      end
    end

    if (OUT_OK) begin : g_out
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cc_pin_out[i] <= 1'b0;
          cc_pin_oe[i] <= 1'b0;
        end else begin
          cc_pin_oe[i] <= cfg.mode inside {dccu_pkg::DCCU_CMP1, dccu_pkg::DCCU_CMP3} ||
                          (ch_dbl[i] && low_half); // RULE_08
          // pin actions land at the edge of the matching timer update
          unique case (cfg.mode)
            dccu_pkg::DCCU_CMP1: begin
              if (ch_match[i]) cc_pin_out[i] <= !cc_pin_out[i]; // RULE_19
            end
            dccu_pkg::DCCU_CMP3: begin
              if (once_ok) begin
                cc_pin_out[i] <= 1'b1; // RULE_20
              end else if (tmr_ovf[ti]) begin
                cc_pin_out[i] <= 1'b0; // RULE_20
              end
            end
            dccu_pkg::DCCU_DOUBLE: begin
              if (low_half && (ch_match[i] || pair_match)) begin
                cc_pin_out[i] <= !cc_pin_out[i]; // RULE_21
              end
            end
            default: cc_pin_out[i] <= cc_pin_out[i];
          endcase
        end
      end
    end else begin : g_in_only
      // these pins are inputs only and never drive
      assign cc_pin_out[i] = 1'b0; // RULE_09
      assign cc_pin_oe[i] = 1'b0; // RULE_09
    end
  end
endmodule
`default_nettype wire

// file: hw/dccu_pkg.sv
// package of constants and types for the dual capture/compare unit
`default_nettype none
package dccu_pkg;
  localparam int NUM_CH = 32;
  localparam int CH_PER_UNIT = 16;
  localparam int NUM_TMR = 4;
  localparam int PAIR_OFS = 8;
  localparam int IN_ONLY_LO = 24;
  localparam int IN_ONLY_HI = 27;
  localparam int AXI_AW = 9;
  // register word indices; byte address is four times the index
  localparam logic [6:0] IDX_VAL = 7'h00;
  localparam logic [6:0] IDX_CFG = 7'h20;
  localparam logic [6:0] IDX_TMR = 7'h40;
  localparam logic [6:0] IDX_RLD = 7'h44;
  localparam logic [6:0] IDX_TCTL = 7'h48;
  localparam logic [6:0] IDX_END = 7'h4C;
  localparam logic [15:0] TMR_MAX = 16'hFFFF;
  localparam logic [15:0] TMR_ONE = 16'h0001;
  localparam logic [15:0] TMR_RST = 16'h0000;
  localparam int PRESC_W = 10;
  localparam logic [10:0] PRESC_BASE = 11'h008;
  localparam logic [10:0] PRESC_ONE = 11'h001;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // finest timer step: clock period times the smallest divider
  localparam int CLK_PERIOD_PS = 5000;
  localparam int MIN_DIV = 8;
  localparam int FINEST_STEP_PS = CLK_PERIOD_PS * MIN_DIV;

  typedef enum logic [2:0] {
    DCCU_OFF, DCCU_CAPTURE, DCCU_CMP0, DCCU_CMP1, DCCU_CMP2, DCCU_CMP3, DCCU_DOUBLE
  } dccu_mode_type;
  typedef enum logic [1:0] {
    DCCU_EDGE_NONE, DCCU_EDGE_RISE, DCCU_EDGE_FALL, DCCU_EDGE_BOTH
  } dccu_edge_type;
  typedef enum logic [1:0] {
    DCCU_SRC_PRESC, DCCU_SRC_GPT, DCCU_SRC_EXT, DCCU_SRC_STOP
  } dccu_src_type;

  // channel config word bits [5:0]
  typedef struct packed {
    dccu_edge_type edge_sel;
    logic tmr_sel;
    dccu_mode_type mode;
  } dccu_ch_cfg_type;
  // timer control word bits [7:0]
  typedef struct packed {
    dccu_edge_type ext_edge;
    logic run;
    dccu_src_type src;
    logic [2:0] timer_input_select;
  } dccu_tmr_ctl_type;
  localparam int CFG_W = $bits(dccu_ch_cfg_type);
  localparam int TCTL_W = $bits(dccu_tmr_ctl_type);
endpackage
`default_nettype wire

// file: tb/dccu_checker_assertions.sv
// port checker for the dual capture/compare unit
`default_nettype none
module dccu_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [dccu_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [dccu_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [dccu_pkg::NUM_CH-1:0] cc_pin_out,
  input wire logic [dccu_pkg::NUM_CH-1:0] cc_pin_oe,
  input wire logic [dccu_pkg::NUM_CH-1:0] cc_irq
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [6:0] aw_idx_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_idx_reg <= 7'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_idx_reg <= s_axi_awaddr[8:2];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  in_only_a: assert property (
    cc_pin_oe[27:24] == 4'h0 && cc_pin_out[27:24] == 4'h0)
    else $error("input-only pin driven");
  pin_rise_a: assert property (
    $rose(cc_pin_out[0]) |-> cc_irq[0] || cc_irq[8])
    else $error("pin rose without a match request");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  wr_refuse_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted during response");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted during response");
  wr_latency_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  rd_unmapped_a: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[8:2] >= dccu_pkg::IDX_END
    |=> s_axi_rvalid && s_axi_rresp == dccu_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  wr_resp_code_a: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp ==
    (aw_idx_reg >= dccu_pkg::IDX_END ? dccu_pkg::RESP_SLVERR : dccu_pkg::RESP_OKAY))
    else $error("write response code wrong");
  wr_cover_c: cover property (s_axi_bvalid && s_axi_bready);
  rd_err_cover_c: cover property (s_axi_rvalid && s_axi_rresp == dccu_pkg::RESP_SLVERR);
  pin_cover_c: cover property ($rose(cc_pin_out[0]));
endmodule
bind dccu_top dccu_checker dccu_checker_i (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_irq(cc_irq));
`default_nettype wire

// file: tb/dccu_pins.sv
// channel pin model: each pin shows the block's level while driven, else the outside level
`default_nettype none
module dccu_pins (
  input wire logic [dccu_pkg::NUM_CH-1:0] cc_pin_out,
  input wire logic [dccu_pkg::NUM_CH-1:0] cc_pin_oe,
  input wire logic [dccu_pkg::NUM_CH-1:0] drive_lvl,
  output logic [dccu_pkg::NUM_CH-1:0] cc_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  assign cc_pin_in = (cc_pin_oe & cc_pin_out) | (~cc_pin_oe & drive_lvl);
endmodule
`default_nettype wire

// file: tb/tb_dual_capture_compare_unit.sv
// self-checking bench for the dual capture/compare unit
`default_nettype none
module tb_dual_capture_compare_unit;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic gpt_ovf_pulse;
  logic [8:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, cc_pin_in, cc_pin_out, cc_pin_oe, cc_irq, drv;
  logic [1:0] s_axi_bresp, s_axi_rresp, ext_count_in;
  logic [3:0] s_axi_wstrb, timer_irq;
  logic [4:0] watch;
  int errors, comparisons, irq_cnt;
  dccu_top dccu_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .gpt_ovf_pulse(gpt_ovf_pulse), .ext_count_in(ext_count_in),
    .cc_pin_in(cc_pin_in), .cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .cc_irq(cc_irq),
    .timer_irq(timer_irq));
  dccu_pins dccu_pins_i (.cc_pin_out(cc_pin_out), .cc_pin_oe(cc_pin_oe), .drive_lvl(drv),
    .cc_pin_in(cc_pin_in));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // counts request pulses of the watched channel
  always @(posedge aclk) begin
    if (cc_irq[watch] === 1'b1) irq_cnt++;
  end
  task automatic stop_test();
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 5000) begin
      errors++;
      stop_test();
    end
  endtask
  // ready is offered with the request and held until the answer is seen
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bready && s_axi_bvalid) && n < 5000);
    s_axi_bready <= 1'b0;
    tmo(n);
    chk({30'h0, s_axi_bresp}, {30'h0, a >= 9'h130 ? 2'h2 : 2'h0});
    @(posedge aclk);
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rready && s_axi_rvalid) && n < 5000);
    s_axi_rready <= 1'b0;
    tmo(n);
    chk(s_axi_rdata, exp);
    chk({30'h0, s_axi_rresp}, {30'h0, a >= 9'h130 ? 2'h2 : 2'h0});
    @(posedge aclk);
  endtask
  task automatic wait_tirq(input int i, output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (timer_irq[i] !== 1'b1 && n < 5000);
    tmo(n);
  endtask
  // both external count lines pulse together, one rising edge each
  task automatic ext_pulse(input int k);
    repeat (k) begin
      ext_count_in <= 2'h3;
      repeat (3) @(posedge aclk);
      ext_count_in <= 2'h0;
      repeat (3) @(posedge aclk);
    end
  endtask
  task automatic regs_test();
    rd(9'h100, 32'h0);
    wr(9'h110, 32'h1234);
    rd(9'h110, 32'h1234);
    wr(9'h07C, 32'hABCD);
    rd(9'h07C, 32'hABCD);
    wr(9'h130, 32'h5555);
    rd(9'h130, 32'h0);
  endtask
  task automatic presc_test();
    int n;
    wr(9'h110, 32'hFFFE);
    for (int k = 0; k < 8; k++) begin
      wr(9'h120, 32'h20 | 32'(k));
      wr(9'h100, 32'hFFFF);
      wait_tirq(0, n);
      wait_tirq(0, n);
      chk(32'(n), 32'(2 * (8 << k)));
    end
    wr(9'h114, 32'h0);
    wr(9'h104, 32'hFFFF);
    wr(9'h124, 32'h28);
    gpt_ovf_pulse <= 1'b1;
    @(posedge aclk);
    gpt_ovf_pulse <= 1'b0;
    wait_tirq(1, n);
    rd(9'h104, 32'h0);
  endtask
  task automatic capture_test();
    wr(9'h120, 32'h70);
    wr(9'h128, 32'h70);
    wr(9'h100, 32'h0);
    wr(9'h108, 32'h0);
    ext_pulse(5);
    rd(9'h100, 32'h5);
    rd(9'h108, 32'h5);
    wr(9'h10C, 32'h77);
    watch <= 5'h18;
    for (int e = 1; e < 4; e++) begin
      wr(9'h0E0, 32'h09 | 32'(e << 4));
      irq_cnt = 0;
      drv[24] <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(32'(irq_cnt), 32'(e & 1));
      drv[24] <= 1'b0;
      repeat (4) @(posedge aclk);
      chk(32'(irq_cnt), 32'((e & 1) + (e >> 1)));
    end
    rd(9'h060, 32'h77);
  endtask
  task automatic compare_test();
    watch <= 5'd1;
    wr(9'h004, 32'h3);
    for (int m = 2; m < 6; m++) begin
      wr(9'h084, 32'(m));
      wr(9'h100, 32'h0);
      irq_cnt = 0;
      ext_pulse(3);
      chk(32'(irq_cnt), 32'h1);
      chk({31'h0, cc_pin_oe[1]}, 32'(m == 3 || m == 5));
      chk({31'h0, cc_pin_out[1]}, 32'(m == 3 || m == 5));
      wr(9'h100, 32'h2);
      ext_pulse(1);
      chk(32'(irq_cnt), 32'(m < 4 ? 2 : 1));
      chk({31'h0, cc_pin_out[1]}, 32'(m == 5));
    end
    wr(9'h000, 32'h1);
    wr(9'h020, 32'h2);
    wr(9'h080, 32'h6);
    wr(9'h0A0, 32'h6);
    wr(9'h100, 32'h0);
    watch <= 5'd8;
    irq_cnt = 0;
    ext_pulse(1);
    chk({31'h0, cc_pin_out[0]}, 32'h1);
    ext_pulse(1);
    chk({31'h0, cc_pin_out[0]}, 32'h0);
    chk(32'(irq_cnt), 32'h1);
  endtask
  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 9'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 9'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    gpt_ovf_pulse = 1'b0;
    ext_count_in = 2'h0;
    drv = 32'h0;
    watch = 5'd0;
    errors = 0;
    comparisons = 0;
    irq_cnt = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    regs_test();
    presc_test();
    capture_test();
    compare_test();
    stop_test();
  end
endmodule
`default_nettype wire
